// File: rpm_ctrl.sv
// Reset source gathering, brownout handling and power mode sequencing
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module rpm_ctrl (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic supply_low,
   input wire logic shared_reset_input_pin,
   input wire logic watchdog_reset_req,
   input wire logic break_detect,
   input wire logic irq_pending,
   input wire logic wake_irq,
   input wire logic keypad_irq,
   input wire logic osc_clock_tick,
   output logic cpu_reset,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic main_osc_en,
   output logic rc_osc_en,
   output logic brownout_det_en,
   output logic comparator_en,
   output logic rtc_run,
   output logic brownout_irq,
   output logic pin_input_value
);
   rpm_wake_if wk ();

   rpm_wake_timer u_wake (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wk(wk.timer)
   );

   function automatic logic is_power_down(input rpm_pkg::rpm_mode_t m);
      is_power_down = (m == rpm_pkg::MODE_PDOWN) || (m == rpm_pkg::MODE_TPDOWN);
   endfunction : is_power_down

   function automatic logic [1:0] reg_index(input logic [3:0] addr);
      reg_index = addr[3:2];
   endfunction : reg_index

   rpm_pkg::rpm_mode_t mode;
   logic [5:0] flags;
   logic [6:0] ctrl;
   logic bo_pending;
   logic bo_cond;
   logic power_up;
   logic wake_start;
   logic aw_full;
   logic w_full;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Write channel: address and data taken in either order
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire wr_fire = aw_full && w_full && !s_axi_bvalid;
   wire next_aw_full = aw_full ? !wr_fire : aw_hs;
   wire next_w_full = w_full ? !wr_fire : w_hs;
   wire [1:0] wr_idx = reg_index(aw_addr);
   wire wr_low = wr_fire && w_strb[0];
   wire wr_rst = wr_low && (wr_idx == reg_index(rpm_pkg::ADDR_RST_SOURCE));
   wire wr_ctrl = wr_low && (wr_idx == reg_index(rpm_pkg::ADDR_CTRL));
   wire wr_mode = wr_low && (wr_idx == reg_index(rpm_pkg::ADDR_MODE));
   wire wr_stat = wr_low && (wr_idx == reg_index(rpm_pkg::ADDR_STATUS));
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire next_rvalid = s_axi_rvalid ? !s_axi_rready : ar_hs;
   wire next_bvalid = s_axi_bvalid ? !s_axi_bready : wr_fire;

   // Control fields
   wire bod_en = ctrl[rpm_pkg::CTRL_BOD_EN];
   wire bo_irq_mode = ctrl[rpm_pkg::CTRL_BO_IRQ];
   wire reset_pin_enable = ctrl[rpm_pkg::CTRL_PIN_RST];
   wire rc_sel = ctrl[rpm_pkg::CTRL_RC_SEL];
   wire rtc_en = ctrl[rpm_pkg::CTRL_RTC_EN];
   wire comp_off = ctrl[rpm_pkg::CTRL_COMP_OFF];

   // pin acts as reset when enabled or during power-up
   wire pin_is_reset = power_up || reset_pin_enable;
   wire pin_reset = pin_is_reset && !shared_reset_input_pin;

   // brownout follows supply while detection is live
   wire bo_cond_now = bod_en && supply_low && (mode != rpm_pkg::MODE_TPDOWN);
   wire bo_rise = bo_cond_now && !bo_cond;
   // reset by default, interrupt when configured
   wire bo_reset = bo_cond_now && !bo_irq_mode;
   wire bo_event = bo_rise && bo_irq_mode;
   wire sw_reset = wr_mode && w_data[rpm_pkg::MODE_SWRST_BIT];

   // six reset sources, power-on handled by reset_n
   logic [5:0] reset_vec;
   always_comb
   begin
      reset_vec = 6'h00;
      reset_vec[rpm_pkg::FLAG_PIN] = pin_reset;
      reset_vec[rpm_pkg::FLAG_BROWNOUT] = bo_reset;
      reset_vec[rpm_pkg::FLAG_WDT] = watchdog_reset_req;
      reset_vec[rpm_pkg::FLAG_SW] = sw_reset;
      reset_vec[rpm_pkg::FLAG_BRK] = break_detect;
   end
   wire any_reset = |reset_vec;

   // write 0 clears, new sources win and accumulate
   wire [5:0] kept_flags = wr_rst ? (flags & w_data[5:0]) : flags;
   wire [5:0] next_flags = kept_flags | reset_vec;

   // pending until acknowledged by writing 1
   wire bo_ack = wr_stat && w_data[rpm_pkg::STAT_BO_PEND];
   wire next_bo_pending = bo_event || (bo_pending && !bo_ack);

   // Mode commands
   wire req_idle = wr_mode && w_data[rpm_pkg::MODE_IDLE_BIT];
   wire req_pd = wr_mode && w_data[rpm_pkg::MODE_PD_BIT];
   wire req_tpd = wr_mode && w_data[rpm_pkg::MODE_TPD_BIT];
   // wake from power-down on reset or wake subset
   wire pd_wake = any_reset || wake_irq || keypad_irq || bo_event;
   // idle ends on any enabled interrupt or reset
   wire idle_wake = any_reset || irq_pending || keypad_irq || bo_event;

   rpm_pkg::rpm_mode_t next_mode;
   always_comb
   begin
      next_mode = mode;
      case (mode)
         rpm_pkg::MODE_RUN:
         begin
            if (any_reset)
               next_mode = rpm_pkg::MODE_RUN;
            else if (req_tpd)
               next_mode = rpm_pkg::MODE_TPDOWN;
            else if (req_pd)
               next_mode = rpm_pkg::MODE_PDOWN;
            else if (req_idle)
               next_mode = rpm_pkg::MODE_IDLE;
         end
         rpm_pkg::MODE_IDLE:
         begin
            if (idle_wake)
               next_mode = rpm_pkg::MODE_RUN;
         end
         rpm_pkg::MODE_PDOWN, rpm_pkg::MODE_TPDOWN:
         begin
            if (pd_wake)
               next_mode = rpm_pkg::MODE_WAKE;
         end
         default:
         begin
            if (wk.done)
               next_mode = rpm_pkg::MODE_RUN;
         end
      endcase
   end

   wire next_wake_start = is_power_down(mode) && pd_wake;
   wire next_power_up = power_up && !(mode == rpm_pkg::MODE_WAKE && wk.done);
   wire next_pd = is_power_down(next_mode);
   wire next_tpd = (next_mode == rpm_pkg::MODE_TPDOWN);

   assign wk.start = wake_start;
   assign wk.crystal = ctrl[rpm_pkg::CTRL_XTAL];
   assign wk.osc_tick = osc_clock_tick;

   // Read decode
   wire [1:0] rd_idx = reg_index(s_axi_araddr);
   logic [31:0] status_word;
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[rpm_pkg::STAT_BO_PEND] = bo_pending;
      status_word[rpm_pkg::STAT_BO_COND] = bo_cond;
      status_word[rpm_pkg::STAT_MODE_LSB +: 3] = 3'(mode);
      status_word[rpm_pkg::STAT_PWR_UP] = power_up;
      status_word[rpm_pkg::STAT_PIN] = shared_reset_input_pin;
   end
   wire [31:0] rd_word = (rd_idx == reg_index(rpm_pkg::ADDR_RST_SOURCE)) ? {26'h000_0000, flags} :
                         (rd_idx == reg_index(rpm_pkg::ADDR_CTRL)) ? {25'h000_0000, ctrl} :
                         (rd_idx == reg_index(rpm_pkg::ADDR_STATUS)) ? status_word :
                         32'h0000_0000;

   // Bus slave state
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rpm_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= rpm_pkg::RESP_OKAY;
      end
      else
      begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         if (aw_hs)
            aw_addr <= s_axi_awaddr;
         if (w_hs)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         s_axi_awready <= !next_aw_full;
         s_axi_wready <= !next_w_full;
         s_axi_bvalid <= next_bvalid;
         if (wr_fire)
            s_axi_bresp <= (aw_addr[1:0] != 2'h0) ? rpm_pkg::RESP_SLVERR : rpm_pkg::RESP_OKAY;
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_hs)
         begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr[1:0] != 2'h0) ? rpm_pkg::RESP_SLVERR : rpm_pkg::RESP_OKAY;
         end
      end
   end

   // Control and status state
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // power-on sets power-on and brownout flags only
         flags <= rpm_pkg::FLAGS_POR;
         ctrl <= rpm_pkg::CTRL_RESET;
         bo_pending <= 1'b0;
         bo_cond <= 1'b0;
         power_up <= 1'b1;
         mode <= rpm_pkg::MODE_WAKE;
         wake_start <= 1'b1;
      end
      else
      begin
         flags <= next_flags;
         if (wr_ctrl)
            ctrl <= w_data[6:0];
         bo_pending <= next_bo_pending;
         bo_cond <= bo_cond_now;
         power_up <= next_power_up;
         mode <= next_mode;
         wake_start <= next_wake_start;
      end
   end

   // Outputs, all registered
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cpu_reset <= 1'b1;
         cpu_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         main_osc_en <= 1'b1;
         rc_osc_en <= 1'b1;
         brownout_det_en <= 1'b1;
         comparator_en <= 1'b1;
         rtc_run <= 1'b0;
         brownout_irq <= 1'b0;
         pin_input_value <= 1'b1;
      end
      else
      begin
         cpu_reset <= any_reset || next_power_up;
         cpu_clk_en <= (next_mode == rpm_pkg::MODE_RUN);
         periph_clk_en <= !next_pd;
         main_osc_en <= !next_pd;
         // in power-down, RC kept only for clock source with timer enabled
         rc_osc_en <= !next_pd || (rc_sel && rtc_en);
         // detector and comparators off in total power-down or when their control bits disable them
         brownout_det_en <= bod_en && !next_tpd;
         comparator_en <= !comp_off && !next_tpd;
         rtc_run <= rtc_en;
         brownout_irq <= next_bo_pending;
         pin_input_value <= pin_is_reset ? 1'b1 : shared_reset_input_pin;
      end
   end

   // brownout in reset mode holds the processor
   bo_reset_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (bod_en && supply_low && !bo_irq_mode && mode != rpm_pkg::MODE_TPDOWN) |=> cpu_reset)
      else $error("brownout did not reset");
   // disabled detection gives no brownout flag
   bo_disabled_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!bod_en && !wr_rst && !flags[rpm_pkg::FLAG_BROWNOUT]) |=> !flags[rpm_pkg::FLAG_BROWNOUT])
      else $error("brownout flag while disabled");
   // pending raised, and still set one cycle later unless acknowledged
   bo_pend_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bo_event |=> brownout_irq ##1 (brownout_irq || $past(bo_ack)))
      else $error("brownout pending lost");
   pof_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (flags[rpm_pkg::FLAG_PWR_ON] && !wr_rst) |=> flags[rpm_pkg::FLAG_PWR_ON])
      else $error("power-on flag dropped");
   flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      watchdog_reset_req |=> flags[rpm_pkg::FLAG_WDT])
      else $error("watchdog flag not set");
   // written zero clears an idle source
   flag_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (wr_rst && !w_data[rpm_pkg::FLAG_SW] && !sw_reset) |=> !flags[rpm_pkg::FLAG_SW])
      else $error("flag not cleared");
   pd_osc_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mode == rpm_pkg::MODE_PDOWN) [*2] |-> !main_osc_en)
      else $error("oscillator running in power-down");
   tpd_bod_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mode == rpm_pkg::MODE_TPDOWN) [*2] |-> (!brownout_det_en && !comparator_en))
      else $error("detector on in total power-down");
   // configured pin low resets after power-up
   pin_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reset_pin_enable && !shared_reset_input_pin) |=> (cpu_reset && flags[rpm_pkg::FLAG_PIN]))
      else $error("pin reset missed");
   idle_exit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (mode == rpm_pkg::MODE_IDLE && irq_pending) |=> (mode == rpm_pkg::MODE_RUN && cpu_clk_en))
      else $error("idle not ended");
endmodule : rpm_ctrl

// File: rpm_pkg.sv
// Constants and types for the reset and power mode controller
// Contract
// - Brownout resets the processor by default, or raises an interrupt when configured.
// - Software enables or disables brownout detection; disabled means no reset or interrupt.
// - Brownout condition follows the supply-low indication while detection is enabled.
// - Power-on flag set at power-up and stays set until software clears it.
// - Idle stops processor clock, peripherals run; enabled interrupt or reset ends idle.
// - Power-down stops main oscillator; any reset or wake interrupt subset ends it.
// - Brownout detector, watchdog, comparators and system timer keep running in power-down.
// - RC oscillator off in power-down unless it is system clock and timer enabled.
// - Total power-down is power-down plus brownout detector and comparators disabled.
// - Reset-pin-enable at 1 makes shared pin an active-low reset, else plain input.
// - During power-up the shared pin always acts as reset input.
// - Only power-up overrides the reset-pin-enable selection; other resets do not.
// - Reset sources: pin, power-on, brownout, watchdog, software, serial break.
// - One readable flag per reset source in the reset source register.
// - Writing 0 to a flag bit clears it; several flags may be set.
// - Power-on reset sets power-on and brownout flags, clears all others.
// - Other resets set their own flag and keep uncleared earlier flags.
// - Clock restart waits 992 or 224 oscillator cycles plus 60 us.
// - Enabled keypad interrupt wakes the processor from idle or power-down.
package rpm_pkg;
   localparam logic [3:0] ADDR_RST_SOURCE = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_MODE = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   // Reset source flag positions
   localparam int FLAG_PIN = 0;
   localparam int FLAG_PWR_ON = 1;
   localparam int FLAG_BROWNOUT = 2;
   localparam int FLAG_WDT = 3;
   localparam int FLAG_SW = 4;
   localparam int FLAG_BRK = 5;
   localparam logic [5:0] FLAGS_POR = 6'h06;
   // Control field positions
   localparam int CTRL_BOD_EN = 0;
   localparam int CTRL_BO_IRQ = 1;
   localparam int CTRL_PIN_RST = 2;
   localparam int CTRL_RC_SEL = 3;
   localparam int CTRL_RTC_EN = 4;
   localparam int CTRL_XTAL = 5;
   localparam int CTRL_COMP_OFF = 6;
   localparam logic [6:0] CTRL_RESET = 7'h01;
   // Mode command positions
   localparam int MODE_IDLE_BIT = 0;
   localparam int MODE_PD_BIT = 1;
   localparam int MODE_TPD_BIT = 2;
   localparam int MODE_SWRST_BIT = 3;
   // Status field positions
   localparam int STAT_BO_PEND = 0;
   localparam int STAT_BO_COND = 1;
   localparam int STAT_MODE_LSB = 2;
   localparam int STAT_PWR_UP = 5;
   localparam int STAT_PIN = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Wake-up timing
   localparam int SYS_CLK_MHZ = 50;
   localparam int WAKE_XTAL_OSC = 992;
   localparam int WAKE_OTHER_OSC = 224;
   localparam int WAKE_MIN_US = 60;
   localparam int WAKE_MIN_CYC = WAKE_MIN_US * SYS_CLK_MHZ;
   typedef enum logic [2:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN, MODE_TPDOWN, MODE_WAKE} rpm_mode_t;
endpackage : rpm_pkg

// File: rpm_wake_if.sv
// Handshake between the mode controller and its wake-up timer
`timescale 1ns/1ps
interface rpm_wake_if;
   logic start;
   logic crystal;
   logic osc_tick;
   logic done;
   modport ctrl (output start, output crystal, output osc_tick, input done);
   modport timer (input start, input crystal, input osc_tick, output done);
endinterface : rpm_wake_if

// File: rpm_wake_timer.sv
// Clock start-up delay: oscillator cycles then a fixed settling time
`timescale 1ns/1ps
module rpm_wake_timer (
   input wire logic sys_clk,
   input wire logic reset_n,
   rpm_wake_if.timer wk
);
   typedef enum logic [1:0] {WT_IDLE, WT_OSC, WT_SETTLE} rpm_wt_state_t;
   rpm_wt_state_t state;
   logic [9:0] osc_cnt;
   logic [11:0] cyc_cnt;
   logic done;
   wire [9:0] osc_target = wk.crystal ? 10'(rpm_pkg::WAKE_XTAL_OSC) : 10'(rpm_pkg::WAKE_OTHER_OSC);
   wire osc_last = wk.osc_tick && (osc_cnt == osc_target - 10'h001);
   wire cyc_last = (cyc_cnt == 12'(rpm_pkg::WAKE_MIN_CYC - 1));
   assign wk.done = done;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= WT_IDLE;
         osc_cnt <= 10'h000;
         cyc_cnt <= 12'h000;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state)
            WT_IDLE:
            begin
               osc_cnt <= 10'h000;
               cyc_cnt <= 12'h000;
               if (wk.start)
                  state <= WT_OSC;
            end
            WT_OSC:
            begin
               if (osc_last)
                  state <= WT_SETTLE;
               else if (wk.osc_tick)
                  osc_cnt <= osc_cnt + 10'h001;
            end
            default:
            begin
               cyc_cnt <= cyc_cnt + 12'h001;
               if (cyc_last)
               begin
                  state <= WT_IDLE;
                  done <= 1'b1;
               end
            end
         endcase
      end
   end

   settle_len_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(state == WT_SETTLE) |-> (state == WT_SETTLE) [*8]) else $error("settle too short");
endmodule : rpm_wake_timer

// File: rpm_far_side.sv
// Far-side model: supply monitor, external reset circuit and oscillator
`timescale 1ns/1ps
module rpm_far_side (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic dip,
   input wire logic pin_low,
   input wire logic wdt_pulse,
   input wire logic brk_pulse,
   input wire logic slow,
   input wire logic osc_on,
   output logic supply_low,
   output logic shared_reset_input_pin,
   output logic watchdog_reset_req,
   output logic break_detect,
   output logic osc_clock_tick
);
   logic phase;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase <= 1'b0;
         supply_low <= 1'b0;
         shared_reset_input_pin <= 1'b1;
         watchdog_reset_req <= 1'b0;
         break_detect <= 1'b0;
         osc_clock_tick <= 1'b0;
      end
      else
      begin
         phase <= ~phase;
         supply_low <= dip;
         shared_reset_input_pin <= ~pin_low;
         watchdog_reset_req <= wdt_pulse;
         break_detect <= brk_pulse;
         // Slow oscillator ticks every other cycle
         osc_clock_tick <= osc_on & (~slow | phase);
      end
   end
endmodule : rpm_far_side

// File: testbench.sv
// Self-checking bench for the reset and power mode controller
`timescale 1ns/1ps
module testbench;
   logic sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic supply_low, shared_reset_input_pin, watchdog_reset_req, break_detect, osc_clock_tick;
   logic irq_pending, wake_irq, keypad_irq, cpu_reset, cpu_clk_en, periph_clk_en;
   logic main_osc_en, rc_osc_en, brownout_det_en, comparator_en, rtc_run, brownout_irq;
   logic pin_input_value, dip, pin_low, wdt_pulse, brk_pulse, slow;
   logic [31:0] rq[$];
   logic [31:0] bq[$];
   int fail_count, tests_run, i;
   rpm_ctrl dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_low, .shared_reset_input_pin,
      .watchdog_reset_req, .break_detect, .irq_pending, .wake_irq, .keypad_irq,
      .osc_clock_tick, .cpu_reset, .cpu_clk_en, .periph_clk_en, .main_osc_en, .rc_osc_en,
      .brownout_det_en, .comparator_en, .rtc_run, .brownout_irq, .pin_input_value);
   rpm_far_side far (.sys_clk, .reset_n, .dip, .pin_low, .wdt_pulse, .brk_pulse, .slow,
      .osc_on(main_osc_en), .supply_low, .shared_reset_input_pin, .watchdog_reset_req,
      .break_detect, .osc_clock_tick);
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
   endfunction : lfsr_next
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      lfsr = lfsr_next(lfsr);
      bq.push_back({30'h0, er});
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {lfsr[31:8], d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cyc(1);
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cyc(1);
   endtask : rd
   // Waits for cpu_reset (sel 0) or cpu_clk_en (sel 1)
   task wait_for(input int sel, input logic v, input int lim);
      int n;
      n = 0;
      while ((sel == 0 ? cpu_reset : cpu_clk_en) !== v && n < lim)
      begin
         @(posedge sys_clk);
         n++;
      end
      check({31'h0, sel == 0 ? cpu_reset : cpu_clk_en}, {31'h0, v});
   endtask : wait_for
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      begin
         check(s_axi_rdata, rq.pop_front());
         check({30'h0, s_axi_rresp}, {30'h0, rpm_pkg::RESP_OKAY});
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
         check({30'h0, s_axi_bresp}, bq.pop_front());
   end
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      give_verdict;
   end
   initial
   begin
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {irq_pending, wake_irq, keypad_irq, dip, pin_low, wdt_pulse, brk_pulse, slow} = '0;
      fail_count = 0;
      tests_run = 0;
      lfsr = 32'h7779_2518;
      cyc(8);
      reset_n <= 1'b1;
      cyc(3200);
      check({31'h0, cpu_reset}, 32'h0000_0001);
      wait_for(0, 1'b0, 400);
      rd(rpm_pkg::ADDR_RST_SOURCE, 32'h0000_0006);
      rd(rpm_pkg::ADDR_CTRL, 32'h0000_0001);
      rd(rpm_pkg::ADDR_STATUS, 32'h0000_0040);
      wr(4'h9, 8'h00, rpm_pkg::RESP_SLVERR);
      pin_low <= 1'b1;
      cyc(3);
      check({30'h0, pin_input_value, cpu_reset}, 32'h0000_0000);
      pin_low <= 1'b0;
      cyc(2);
      wr(rpm_pkg::ADDR_CTRL, 8'h05, rpm_pkg::RESP_OKAY);
      pin_low <= 1'b1;
      cyc(3);
      check({30'h0, pin_input_value, cpu_reset}, 32'h0000_0003);
      pin_low <= 1'b0;
      wait_for(0, 1'b0, 20);
      rd(rpm_pkg::ADDR_CTRL, 32'h0000_0005);
      rd(rpm_pkg::ADDR_RST_SOURCE, 32'h0000_0007);
      wr(rpm_pkg::ADDR_RST_SOURCE, 8'h01, rpm_pkg::RESP_OKAY);
      rd(rpm_pkg::ADDR_RST_SOURCE, 32'h0000_0001);
      for (i = 0; i < 3; i++)
      begin
         if (i == 0)
            wdt_pulse <= 1'b1;
         if (i == 1)
            brk_pulse <= 1'b1;
         if (i == 2)
            wr(rpm_pkg::ADDR_MODE, 8'h08, rpm_pkg::RESP_OKAY);
         cyc(1);
         {wdt_pulse, brk_pulse} <= 2'b00;
         cyc(2);
         if (i < 2)
            check({31'h0, cpu_reset}, 32'h0000_0001);
         wait_for(0, 1'b0, 20);
         rd(rpm_pkg::ADDR_RST_SOURCE, i == 0 ? 32'h0000_0009 : i == 1 ? 32'h0000_0029 :
            32'h0000_0039);
      end
      wr(rpm_pkg::ADDR_RST_SOURCE, 8'h00, rpm_pkg::RESP_OKAY);
      rd(rpm_pkg::ADDR_RST_SOURCE, 32'h0000_0000);
      dip <= 1'b1;
      cyc(3);
      check({31'h0, cpu_reset}, 32'h0000_0001);
      rd(rpm_pkg::ADDR_STATUS, 32'h0000_0042);
      dip <= 1'b0;
      wait_for(0, 1'b0, 20);
      rd(rpm_pkg::ADDR_RST_SOURCE, 32'h0000_0004);
      wr(rpm_pkg::ADDR_CTRL, 8'h00, rpm_pkg::RESP_OKAY);
      dip <= 1'b1;
      cyc(3);
      check({30'h0, cpu_reset, brownout_irq}, 32'h0000_0000);
      rd(rpm_pkg::ADDR_STATUS, 32'h0000_0040);
      dip <= 1'b0;
      wr(rpm_pkg::ADDR_CTRL, 8'h03, rpm_pkg::RESP_OKAY);
      dip <= 1'b1;
      cyc(3);
      check({30'h0, cpu_reset, brownout_irq}, 32'h0000_0001);
      dip <= 1'b0;
      cyc(5);
      rd(rpm_pkg::ADDR_STATUS, 32'h0000_0041);
      wr(rpm_pkg::ADDR_STATUS, 8'h01, rpm_pkg::RESP_OKAY);
      cyc(2);
      check({31'h0, brownout_irq}, 32'h0000_0000);
      wr(rpm_pkg::ADDR_MODE, 8'h01, rpm_pkg::RESP_OKAY);
      cyc(2);
      check({30'h0, cpu_clk_en, periph_clk_en}, 32'h0000_0001);
      rd(rpm_pkg::ADDR_STATUS, 32'h0000_0044);
      irq_pending <= 1'b1;
      cyc(1);
      irq_pending <= 1'b0;
      wait_for(1, 1'b1, 10);
      wr(rpm_pkg::ADDR_CTRL, 8'h11, rpm_pkg::RESP_OKAY);
      slow <= 1'b1;
      wr(rpm_pkg::ADDR_MODE, 8'h02, rpm_pkg::RESP_OKAY);
      cyc(2);
      check({25'h0, main_osc_en, periph_clk_en, rc_osc_en, brownout_det_en, comparator_en,
         rtc_run, cpu_clk_en}, 32'h0000_000E);
      wake_irq <= 1'b1;
      cyc(1);
      wake_irq <= 1'b0;
      cyc(3400);
      check({31'h0, cpu_clk_en}, 32'h0000_0000);
      wait_for(1, 1'b1, 300);
      wr(rpm_pkg::ADDR_CTRL, 8'h59, rpm_pkg::RESP_OKAY);
      wr(rpm_pkg::ADDR_MODE, 8'h02, rpm_pkg::RESP_OKAY);
      cyc(2);
      check({29'h0, main_osc_en, rc_osc_en, comparator_en}, 32'h0000_0002);
      keypad_irq <= 1'b1;
      cyc(1);
      keypad_irq <= 1'b0;
      wait_for(1, 1'b1, 4000);
      slow <= 1'b0;
      wr(rpm_pkg::ADDR_CTRL, 8'h25, rpm_pkg::RESP_OKAY);
      wr(rpm_pkg::ADDR_MODE, 8'h04, rpm_pkg::RESP_OKAY);
      cyc(2);
      check({28'h0, main_osc_en, rc_osc_en, brownout_det_en, comparator_en}, 32'h0000_0000);
      rd(rpm_pkg::ADDR_STATUS, 32'h0000_004C);
      keypad_irq <= 1'b1;
      cyc(1);
      keypad_irq <= 1'b0;
      cyc(3900);
      check({31'h0, cpu_clk_en}, 32'h0000_0000);
      wait_for(1, 1'b1, 300);
      wdt_pulse <= 1'b1;
      cyc(1);
      wdt_pulse <= 1'b0;
      wait_for(0, 1'b0, 20);
      reset_n <= 1'b0;
      cyc(2);
      reset_n <= 1'b1;
      wait_for(0, 1'b0, 4000);
      rd(rpm_pkg::ADDR_RST_SOURCE, 32'h0000_0006);
      give_verdict;
   end
endmodule : testbench
